/* File: rtl/i2cmbe_engine.sv */
/*
 * Master byte engine of a two-wire serial port: transmit, receive,
 * acknowledge and stop sequences with clock stretching support.
 * Assumes software pulses write/read/enable strobes for one clock and that
 * pull-ups on the bus lines resolve the open-drain outputs.
 */
// Functional notes
// (RQ1) Buffer write sets full flag, starts counter.
// (RQ2) Data changes after SCL falls; low/high baud.
// (RQ3) Full flag clears after eight bits shifted.
// (RQ4) Ninth fall samples SDA into ack status.
// (RQ5) After ninth clock: interrupt, halt, SCL low.
// (RQ6) Busy buffer write discarded, collision flag set.
// (RQ7) Software alone clears the collision flag.
// (RQ8) Receive enable honoured only when idle.
// (RQ9) Receive toggles SCL per rollover, shifts SDA.
// (RQ10) Eighth fall: buffer load, flags, idle.
// (RQ11) Buffer read clears full flag in receive.
// (RQ12) Byte completes while full sets overflow.
// (RQ13) Ack enable pulls SCL low, drives ack bit.
// (RQ14) Software sets ack data bit beforehand.
// (RQ15) Ack: wait, release, high period, low, idle.
// (RQ16) Stop: SDA low, release SCL, release SDA.
// (RQ17) SDA high with SCL high flags stop detected.
// (RQ18) Software checks bus busy before taking it.
// (RQ19) Released SCL pauses counter until high.
// (RQ20) Keeps receiving and wakes in sleep.
// (RQ21) Reset disables module, aborts transfer.
// (RQ22) Counter reloads, counts down twice, stops.
`timescale 1ns/1ps
module i2cmbe_engine
(
	input  wire logic                            clock,
	input  wire logic                            reset_n,
	input  wire logic [i2cmbe_pkg::RELOAD_W-1:0] baud_reload,
	input  wire logic [7:0]                      buf_wdata,
	input  wire logic                            buf_write,
	input  wire logic                            buf_read,
	input  wire logic                            recv_start,
	input  wire logic                            ack_start,
	input  wire logic                            ack_data_bit,
	input  wire logic                            stop_start,
	input  wire logic                            collision_clear,
	input  wire logic                            overflow_clear,
	input  wire logic                            interrupt_clear,
	input  wire logic                            interrupt_enable,
	input  wire logic                            sleep_mode,
	input  wire logic                            scl_in,
	input  wire logic                            sda_in,
	output logic                                 scl_out,
	output logic                                 scl_oe,
	output logic                                 sda_out,
	output logic                                 sda_oe,
	output logic [7:0]                           serial_buffer,
	output logic                                 buffer_full_flag,
	output logic                                 write_collision_flag,
	output logic                                 receive_overflow_flag,
	output logic                                 ack_status_bit,
	output logic                                 receive_enable_bit,
	output logic                                 ack_sequence_enable,
	output logic                                 stop_enable_bit,
	output logic                                 stop_detected,
	output logic                                 port_interrupt_flag,
	output logic                                 wake_request
);
	import i2cmbe_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	i2cmbe_state_t state_reg;        // Sequence state.
	logic [7:0]    shift_register;   // Transmit and receive shifter.
	logic [3:0]    bit_count_reg;    // Clocks finished in this byte.
	logic          scl_low_reg;      // Master pulls SCL low.
	logic          sda_low_reg;      // Master pulls SDA low.
	logic          scl_s;            // Synchronised SCL level.
	logic          sda_s;            // Synchronised SDA level.
	logic          scl_prev_reg;     // SCL one clock earlier.
	logic          sda_prev_reg;     // SDA one clock earlier.
	logic          baud_load;        // Reload strobe for the counter.
	logic          baud_run;         // Counting permitted.
	logic          baud_expired;     // One baud period ended.
	logic          busy;             // A sequence is underway.
	logic          byte_done;        // Receive byte completed.
	logic          tx_done;          // Ninth transmit clock ended.
	logic          stop_done;        // Stop sequence completed.
	logic          ack_done;         // Ack sequence completed.
	logic          load_on_high;     // Released SCL just read high.

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	i2cmbe_sync u_scl_sync
	(
		.clock    (clock),
		.reset_n  (reset_n),
		.async_in (scl_in),
		.sync_out (scl_s)
	);

	i2cmbe_sync u_sda_sync
	(
		.clock    (clock),
		.reset_n  (reset_n),
		.async_in (sda_in),
		.sync_out (sda_s)
	);

	// ------------------------------------------------------------
	// Baud counter
	// ------------------------------------------------------------
	i2cmbe_baud u_baud
	(
		.clock   (clock),
		.reset_n (reset_n),
		.load    (baud_load),
		.run     (baud_run),
		.reload  (baud_reload),
		.expired (baud_expired)
	);

	// Idle means no sequence is running.
	assign busy = (state_reg != I2CMBE_IDLE);

	// High phases count only once SCL truly reads high.
	assign load_on_high = scl_s && !scl_prev_reg;

	// Completion strobes for the flag logic.
	assign tx_done   = (state_reg == I2CMBE_TX_HIGH) && baud_expired &&
	                   (bit_count_reg == ACK_BIT_NUM - 4'h1);
	assign byte_done = (state_reg == I2CMBE_RX_HIGH) && baud_expired &&
	                   (bit_count_reg == BYTE_BITS - 4'h1);
	assign ack_done  = (state_reg == I2CMBE_ACK_END) && baud_expired;
	assign stop_done = (state_reg == I2CMBE_STOP_DONE) && baud_expired;

	// Counter control: reload on entry strobes, pause while SCL stretched.
	always_comb
	begin
		baud_load = 1'b0;
		baud_run  = 1'b1;
		case (state_reg)
			I2CMBE_IDLE:
			begin
				// (RQ1) Buffer write starts counter.
				baud_load = (buf_write || (recv_start && !ack_start && !stop_start) ||
				             ack_start);
			end
			I2CMBE_TX_HIGH, I2CMBE_RX_HIGH, I2CMBE_ACK_HIGH, I2CMBE_STOP_SCL:
			begin
				// (RQ19) Pause until SCL high; expiry times the next low phase.
				baud_run  = scl_s;
				baud_load = load_on_high || baud_expired;
			end
			I2CMBE_STOP_SDA:
			begin
				// (RQ17) Time one period once the stop is seen.
				baud_load = sda_s && scl_s;
			end
			I2CMBE_STOP_LOW:
			begin
				// (RQ16) Count once SDA low.
				baud_load = !sda_s && sda_prev_reg;
			end
			default:
			begin
				baud_load = baud_expired;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Edge history
	// ------------------------------------------------------------
	// Previous synchronised levels feed edge detection.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	// ------------------------------------------------------------
	// Sequence state machine
	// ------------------------------------------------------------
	// (RQ21) Reset aborts transfer, idles module.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg      <= I2CMBE_IDLE;
			shift_register <= BUF_RESET;
			bit_count_reg  <= 4'h0;
			scl_low_reg    <= 1'b0;
			sda_low_reg    <= 1'b0;
		end
		else
		begin
			case (state_reg)
				I2CMBE_IDLE:
				begin
					if (buf_write)
					begin
						// (RQ2) Data placed while SCL held low.
						shift_register <= buf_wdata;
						bit_count_reg  <= 4'h0;
						scl_low_reg    <= 1'b1;
						sda_low_reg    <= !buf_wdata[7];
						state_reg      <= I2CMBE_TX_LOW;
					end
					else if (ack_start)
					begin
						// (RQ13) SCL low, ack bit on SDA.
						scl_low_reg <= 1'b1;
						sda_low_reg <= !ack_data_bit;
						state_reg   <= I2CMBE_ACK_LOW;
					end
					else if (stop_start)
					begin
						// (RQ16) Drive SDA low first.
						sda_low_reg <= 1'b1;
						state_reg   <= I2CMBE_STOP_LOW;
					end
					else if (recv_start)
					begin
						// (RQ8) Receive only from idle.
						bit_count_reg <= 4'h0;
						scl_low_reg   <= 1'b1;
						sda_low_reg   <= 1'b0;
						state_reg     <= I2CMBE_RX_LOW;
					end
				end
				I2CMBE_TX_LOW:
				begin
					if (baud_expired)
					begin
						// (RQ2) Release SCL after one period.
						scl_low_reg <= 1'b0;
						state_reg   <= I2CMBE_TX_HIGH;
					end
				end
				I2CMBE_TX_HIGH:
				begin
					if (baud_expired)
					begin
						scl_low_reg   <= 1'b1;
						bit_count_reg <= bit_count_reg + 4'h1;
						if (bit_count_reg == ACK_BIT_NUM - 4'h1)
						begin
							// (RQ5) Halt, SCL low, SDA unchanged.
							state_reg <= I2CMBE_IDLE;
						end
						else
						begin
							// (RQ3) After eighth bit release SDA.
							shift_register <= {shift_register[6:0], 1'b1};
							sda_low_reg    <= !shift_register[6] &&
							                  (bit_count_reg < BYTE_BITS - 4'h1);
							state_reg      <= I2CMBE_TX_LOW;
						end
					end
				end
				I2CMBE_RX_LOW:
				begin
					if (baud_expired)
					begin
						// (RQ9) Rollover toggles SCL high.
						scl_low_reg <= 1'b0;
						state_reg   <= I2CMBE_RX_HIGH;
					end
				end
				I2CMBE_RX_HIGH:
				begin
					if (baud_expired)
					begin
						// (RQ9) Shift in sampled SDA.
						shift_register <= {shift_register[6:0], sda_s};
						scl_low_reg    <= 1'b1;
						bit_count_reg  <= bit_count_reg + 4'h1;
						// (RQ10) Eighth fall returns idle.
						state_reg      <= (bit_count_reg == BYTE_BITS - 4'h1) ?
						                  I2CMBE_IDLE : I2CMBE_RX_LOW;
					end
				end
				I2CMBE_ACK_LOW:
				begin
					if (baud_expired)
					begin
						// (RQ15) Release SCL after one period.
						scl_low_reg <= 1'b0;
						state_reg   <= I2CMBE_ACK_HIGH;
					end
				end
				I2CMBE_ACK_HIGH:
				begin
					if (baud_expired)
					begin
						// (RQ15) Pull SCL low, then finish.
						scl_low_reg <= 1'b1;
						state_reg   <= I2CMBE_ACK_END;
					end
				end
				I2CMBE_ACK_END:
				begin
					if (baud_expired)
					begin
						state_reg <= I2CMBE_IDLE;
					end
				end
				I2CMBE_STOP_LOW:
				begin
					if (baud_expired)
					begin
						// (RQ16) Release SCL after one period.
						scl_low_reg <= 1'b0;
						state_reg   <= I2CMBE_STOP_SCL;
					end
				end
				I2CMBE_STOP_SCL:
				begin
					if (baud_expired)
					begin
						// (RQ16) Release SDA one period later.
						sda_low_reg <= 1'b0;
						state_reg   <= I2CMBE_STOP_SDA;
					end
				end
				I2CMBE_STOP_SDA:
				begin
					if (sda_s && scl_s)
					begin
						state_reg <= I2CMBE_STOP_DONE;
					end
				end
				I2CMBE_STOP_DONE:
				begin
					if (baud_expired)
					begin
						state_reg <= I2CMBE_IDLE;
					end
				end
				default:
				begin
					state_reg <= I2CMBE_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Serial buffer and full flag
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			serial_buffer    <= BUF_RESET;
			buffer_full_flag <= 1'b0;
		end
		else
		begin
			if (byte_done)
			begin
				// (RQ10) Copy shifter, set full.
				serial_buffer    <= {shift_register[6:0], sda_s};
				buffer_full_flag <= 1'b1;
			end
			else if (!busy && buf_write)
			begin
				// (RQ1) Write sets full flag.
				serial_buffer    <= buf_wdata;
				buffer_full_flag <= 1'b1;
			end
			else if ((state_reg == I2CMBE_TX_HIGH) && baud_expired &&
			         (bit_count_reg == BYTE_BITS - 4'h1))
			begin
				// (RQ3) Clear after eight bits.
				buffer_full_flag <= 1'b0;
			end
			else if (buf_read)
			begin
				// (RQ11) Read clears full flag.
				buffer_full_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Sticky status flags and wake pulse
	// ------------------------------------------------------------
	// Set wins over a clear arriving in the same cycle.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			write_collision_flag  <= 1'b0;
			receive_overflow_flag <= 1'b0;
			port_interrupt_flag   <= 1'b0;
			stop_detected         <= 1'b0;
			ack_status_bit        <= 1'b0;
			wake_request          <= 1'b0;
		end
		else
		begin
			// (RQ6) Busy write sets collision.
			if (busy && buf_write)
				write_collision_flag <= 1'b1;
			else if (collision_clear)
				// (RQ7) Cleared only by software.
				write_collision_flag <= 1'b0;
			// (RQ12) Byte while still full.
			if (byte_done && buffer_full_flag)
				receive_overflow_flag <= 1'b1;
			else if (overflow_clear)
				receive_overflow_flag <= 1'b0;
			// (RQ4) Ninth fall samples ack.
			if (tx_done)
				ack_status_bit <= sda_s;
			// (RQ17) Stop detected, later interrupt.
			if ((state_reg == I2CMBE_STOP_SDA) && sda_s && scl_s)
				stop_detected <= 1'b1;
			else if (!busy && buf_write)
				stop_detected <= 1'b0;
			// (RQ5) Interrupt after ninth clock.
			if (tx_done || byte_done || stop_done)
				port_interrupt_flag <= 1'b1;
			else if (interrupt_clear)
				port_interrupt_flag <= 1'b0;
			// (RQ20) Completed byte wakes sleeping processor.
			wake_request <= sleep_mode && interrupt_enable && (byte_done || tx_done);
		end
	end

	// ------------------------------------------------------------
	// Control enable bits
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			receive_enable_bit  <= 1'b0;
			ack_sequence_enable <= 1'b0;
			stop_enable_bit     <= 1'b0;
		end
		else
		begin
			if (!busy && recv_start && !buf_write && !ack_start && !stop_start)
				// (RQ8) Set only when idle.
				receive_enable_bit <= 1'b1;
			else if (byte_done)
				// (RQ10) Cleared at eighth fall.
				receive_enable_bit <= 1'b0;
			if (!busy && ack_start && !buf_write)
				ack_sequence_enable <= 1'b1;
			else if (ack_done)
				// (RQ15) Cleared at sequence end.
				ack_sequence_enable <= 1'b0;
			if (!busy && stop_start && !buf_write && !ack_start)
				stop_enable_bit <= 1'b1;
			else if (stop_done)
				// (RQ17) Cleared one period later.
				stop_enable_bit <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Open-drain pin drivers
	// ------------------------------------------------------------
	// Outputs always low; enable high pulls the line.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_out <= 1'b0;
			scl_oe  <= 1'b0;
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end
		else
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe  <= scl_low_reg;
			sda_oe  <= sda_low_reg;
		end
	end

endmodule : i2cmbe_engine

/* File: shared/i2cmbe_pkg.sv */
/*
 * Constants shared by the two-wire master byte engine and its helpers.
 * Assumes a 100 MHz system clock; one instruction cycle is modelled as four clocks.
 */
package i2cmbe_pkg;

	// ------------------------------------------------------------
	// Timing constants
	// ------------------------------------------------------------
	// Width of the baud counter reload field.
	localparam int RELOAD_W = 7;
	// Bits in one byte.
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Clock count of the ninth (acknowledge) bit.
	localparam logic [3:0] ACK_BIT_NUM = 4'h9;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	// Reset value of the serial buffer.
	localparam logic [7:0] BUF_RESET = 8'h00;

	// Engine states.
	typedef enum logic [3:0] {
		I2CMBE_IDLE,
		I2CMBE_TX_LOW,
		I2CMBE_TX_HIGH,
		I2CMBE_RX_LOW,
		I2CMBE_RX_HIGH,
		I2CMBE_ACK_LOW,
		I2CMBE_ACK_HIGH,
		I2CMBE_ACK_END,
		I2CMBE_STOP_LOW,
		I2CMBE_STOP_SCL,
		I2CMBE_STOP_SDA,
		I2CMBE_STOP_DONE
	} i2cmbe_state_t;

endpackage : i2cmbe_pkg

/* File: rtl/i2cmbe_sync.sv */
/*
 * Two-flip-flop synchroniser for one pin input.
 * Assumes the input is asynchronous to clock.
 */
`timescale 1ns/1ps
module i2cmbe_sync
(
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic async_in,
	output logic      sync_out
);
	import i2cmbe_pkg::*;

	// First stage, read only by the second stage.
	logic meta_reg;

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	// Idle bus level is high, so both stages reset high.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_reg <= 1'b1;
			sync_out <= 1'b1;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : i2cmbe_sync

/* File: rtl/i2cmbe_baud.sv */
/*
 * Reloadable baud counter for the byte engine.
 * Assumes reload and run come from logic on the same clock.
 */
`timescale 1ns/1ps
module i2cmbe_baud
(
	input  wire logic                            clock,
	input  wire logic                            reset_n,
	input  wire logic                            load,
	input  wire logic                            run,
	input  wire logic [i2cmbe_pkg::RELOAD_W-1:0] reload,
	output logic                                 expired
);
	import i2cmbe_pkg::*;

	logic [RELOAD_W-1:0] count_reg;  // Remaining decrements.
	logic                tick_reg;   // Half-instruction-cycle phase.
	logic                active_reg; // Counter is counting.

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// (RQ22) Load, count down twice per cycle, stop at zero.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_reg  <= '0;
			tick_reg   <= 1'b0;
			active_reg <= 1'b0;
			expired    <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			if (load)
			begin
				// A fresh reload restarts the period.
				count_reg  <= reload;
				tick_reg   <= 1'b0;
				active_reg <= 1'b1;
			end
			else if (active_reg && run)
			begin
				tick_reg <= ~tick_reg;
				if (tick_reg)
				begin
					if (count_reg == '0)
					begin
						// Rollover reached; stop until reloaded.
						active_reg <= 1'b0;
						expired    <= 1'b1;
					end
					else
					begin
						count_reg <= count_reg - 1'b1;
					end
				end
			end
		end
	end

endmodule : i2cmbe_baud

/* File: bench/i2cmbe_chk.sv */
/* Port checker for the two-wire byte engine.
   Bound onto i2cmbe_engine from tb_top. */
`timescale 1ns/1ps
module i2cmbe_chk
(
	input wire logic [i2cmbe_pkg::RELOAD_W-1:0]	baud_reload,
	input wire logic				clock,
	reset_n,
	buf_write,
	recv_start,
	ack_data_bit,
	collision_clear,
	interrupt_enable,
	sleep_mode,
	scl_in,
	scl_oe,
	sda_oe,
	buffer_full_flag,
	write_collision_flag,
	receive_overflow_flag,
	receive_enable_bit,
	ack_sequence_enable,
	stop_enable_bit,
	stop_detected,
	port_interrupt_flag,
	wake_request
);
	import i2cmbe_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Clocks the line has been high, saturating; reset means long high.
	logic [7:0] hi_cnt_reg;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			hi_cnt_reg <= 8'hff;
		else if (!scl_in)
			hi_cnt_reg <= 8'h00;
		else if (hi_cnt_reg != 8'hff)
			hi_cnt_reg <= hi_cnt_reg + 8'h01;
	end
	chk_write_taken: assert property (buf_write |=> buffer_full_flag || write_collision_flag)
		else $error("buffer write neither taken nor refused");
	chk_coll_sticky: assert property (write_collision_flag && !collision_clear
		|=> write_collision_flag) else $error("collision flag dropped by itself");
	chk_sda_steady: assert property (!scl_oe && !$past(scl_oe) && !stop_enable_bit
		|-> $stable(sda_oe)) else $error("data moved while clock high");
	chk_irq_cause: assert property ($rose(port_interrupt_flag) && !$past(stop_enable_bit)
		|=> scl_oe) else $error("interrupt without parked clock");
	chk_rx_done: assert property ($fell(receive_enable_bit)
		|-> buffer_full_flag && port_interrupt_flag) else $error("receive end flags missing");
	chk_recv_busy: assert property (recv_start && (ack_sequence_enable || stop_enable_bit)
		|=> !receive_enable_bit) else $error("receive taken while busy");
	chk_ack_drive: assert property ($rose(ack_sequence_enable)
		|=> scl_oe && (sda_oe != ack_data_bit)) else $error("ack level not driven");
	chk_stop_end: assert property ($fell(stop_enable_bit)
		|-> stop_detected && port_interrupt_flag) else $error("stop end flags missing");
	chk_ovf_cause: assert property ($rose(receive_overflow_flag)
		|-> $past(buffer_full_flag)) else $error("overflow without full buffer");
	chk_wake_gated: assert property (wake_request
		|-> (sleep_mode && interrupt_enable) ##1 !wake_request) else $error("bad wake pulse");
	chk_scl_high_min: assert property ($rose(scl_oe)
		|-> hi_cnt_reg >= {baud_reload, 1'b0}) else $error("clock high time too short");
endmodule : i2cmbe_chk

/* File: bench/i2cmbe_slave.sv */
/* Behavioural slave on the two-wire bus.
   Assumes pull-ups on both lines; it only ever pulls them low. */
`timescale 1ns/1ps
module i2cmbe_slave
(
	input wire logic	scl,
	input wire logic	clear,
	input wire logic	rx_mode,
	input wire logic	nack,
	input wire logic	stretch,
	input wire logic [7:0]	tx_byte,
	output logic		scl_pull,
	output logic		sda_pull
);
	int cnt;	// Clock rises since the last restart.
	initial
	begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		cnt = 0;
	end
	// Restart: clear count, present first bit.
	always @(posedge clear)
	begin
		cnt = 0;
		sda_pull = rx_mode && !tx_byte[7];
	end
	always @(posedge scl)
		cnt = cnt + 1;
	// Data moves after each fall; clock may be stretched.
	always @(negedge scl)
	begin
		#40;
		if (rx_mode)
			sda_pull = (cnt < 8) && !tx_byte[7 - cnt];
		else
			sda_pull = (cnt == 8) && !nack;
		if (stretch)
		begin
			scl_pull = 1'b1;
			#300;
			scl_pull = 1'b0;
		end
	end
endmodule : i2cmbe_slave

/* File: bench/tb_top.sv */
/* Self-checking bench for the two-wire byte engine.
   Assumes open-drain lines with pull-ups and one slave model. */
`timescale 1ns/1ps
module tb_top;
	import i2cmbe_pkg::*;
	logic clock = 1'b0, reset_n = 1'b0, ack_data_bit = 1'b0;
	logic [RELOAD_W-1:0] baud_reload = 7'h03;
	logic [7:0] buf_wdata = 8'h00, sl_byte = 8'h00, cap, serial_buffer;
	logic buf_write = 1'b0, buf_read = 1'b0, recv_start = 1'b0, ack_start = 1'b0;
	logic stop_start = 1'b0, collision_clear = 1'b0, overflow_clear = 1'b0;
	logic interrupt_clear = 1'b0, interrupt_enable = 1'b0, sleep_mode = 1'b0;
	logic sl_clear = 1'b0, sl_rx = 1'b0, sl_nack = 1'b0, sl_stretch = 1'b0;
	logic scl_oe, sda_oe, buffer_full_flag, write_collision_flag, receive_overflow_flag;
	logic ack_status_bit, receive_enable_bit, ack_sequence_enable, stop_enable_bit;
	logic stop_detected, port_interrupt_flag, wake_request, scl_pull, sda_pull;
	int mismatches = 0, tests_run = 0, wake_seen = 0;
	// Wired-AND lines with pull-ups.
	wire scl_w = !(scl_oe | scl_pull);
	wire sda_w = !(sda_oe | sda_pull);
	always #5 clock = ~clock;
	always @(posedge clock) if (wake_request === 1'b1) wake_seen++;
	i2cmbe_engine DUT
	(
		.clock, .reset_n, .baud_reload, .buf_wdata, .buf_write, .buf_read, .recv_start,
		.ack_start, .ack_data_bit, .stop_start, .collision_clear, .overflow_clear,
		.interrupt_clear, .interrupt_enable, .sleep_mode, .scl_in(scl_w), .sda_in(sda_w),
		.scl_out(), .scl_oe, .sda_out(), .sda_oe, .serial_buffer, .buffer_full_flag,
		.write_collision_flag, .receive_overflow_flag, .ack_status_bit,
		.receive_enable_bit, .ack_sequence_enable, .stop_enable_bit, .stop_detected,
		.port_interrupt_flag, .wake_request
	);
	i2cmbe_slave slave (.scl(scl_w), .clear(sl_clear), .rx_mode(sl_rx), .nack(sl_nack),
		.stretch(sl_stretch), .tx_byte(sl_byte), .scl_pull, .sda_pull);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// k: 0 wr, 1 rx, 2 ack, 3 stop, 4 rd, 5/7 wr/rx no restart, 6 clears.
	task automatic go(input int k, input logic [7:0] d);
		@(posedge clock);
		buf_wdata <= d;
		buf_write <= (k == 0) || (k == 5);
		recv_start <= (k == 1) || (k == 7);
		{ack_start, stop_start, buf_read} <= {k == 2, k == 3, k == 4};
		{collision_clear, overflow_clear} <= {k == 6, k == 6};
		{interrupt_clear, sl_clear} <= {k < 5, k < 2};
		@(posedge clock);
		{buf_write, recv_start, ack_start, stop_start, buf_read} <= 5'h00;
		{collision_clear, overflow_clear, interrupt_clear, sl_clear} <= 4'h0;
		#1;
	endtask : go
	// Bounded wait for the interrupt (k=0) or for the ack enable to drop.
	task automatic wait_end(input int k);
		int n;
		n = 0;
		while (n < 3000 && (k ? ack_sequence_enable : !port_interrupt_flag) !== 1'b0)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		// Let the parked clock reach its pin.
		@(posedge clock);
		#1;
		check("sequence end", n < 3000, 1'b1);
	endtask : wait_end
	task automatic t_tx(input logic [7:0] d, input logic nack, input logic str);
		@(posedge clock);
		{sl_rx, sl_nack, sl_stretch} <= {1'b0, nack, str};
		go(0, d);
		check("full set", buffer_full_flag, 1'b1); // on write
		for (int i = 0; i < 8; i++)
		begin
			@(posedge scl_w);
			cap = {cap[6:0], sda_w};
			if (i == 2)
			begin
				go(5, ~d);
				check("collision", write_collision_flag, 1'b1); // refused
				check("buffer kept", serial_buffer, d); // unchanged
			end
		end
		wait_end(0);
		check("tx byte", cap, d); // bit order
		check("full clear", buffer_full_flag, 1'b0); // cleared
		check("ack status", ack_status_bit, nack); // slot level
		check("scl parked", scl_w, 1'b0); // held low
		check("coll sticky", write_collision_flag, 1'b1); // kept
		go(6, d);
		check("coll clear", write_collision_flag, 1'b0); // cleared
		$display("test tx %h done", d);
	endtask : t_tx
	task automatic t_rx(input logic [7:0] d, input logic ovf);
		@(posedge clock);
		{sl_rx, sl_byte} <= {1'b1, d};
		go(1, d);
		wait_end(0);
		check("rx enable", receive_enable_bit, 1'b0); // self clear
		check("full", buffer_full_flag, 1'b1); // set
		check("overflow", receive_overflow_flag, ovf); // second byte
		if (!ovf)
			check("rx byte", serial_buffer, d); // shifted in
		check("wake", wake_seen != 0, 1'b1); // woken
		$display("test rx %h done", d);
	endtask : t_rx
	task automatic t_ack(input logic b);
		@(posedge clock) ack_data_bit <= b;
		go(2, 8'h00);
		go(7, 8'h00);
		@(posedge scl_w);
		check("ack bit", sda_w, b); // driven
		wait_end(1);
		check("rx ignored", receive_enable_bit, 1'b0); // busy
		check("scl low", scl_w, 1'b0); // parked
		$display("test ack %b done", b);
	endtask : t_ack
	task automatic t_stop();
		go(3, 8'h00);
		@(posedge scl_w);
		check("sda low at rise", sda_w, 1'b0); // order
		wait_end(0);
		check("stop seen", stop_detected, 1'b1); // detected
		check("stop enable", stop_enable_bit, 1'b0); // cleared
		check("lines free", {scl_w, sda_w}, 2'b11); // released
		$display("test stop done");
	endtask : t_stop
	task automatic t_reset();
		check("bus free", stop_detected, 1'b1); // checked first
		go(0, 8'h66);
		repeat (20) @(posedge clock);
		reset_n <= 1'b0;
		@(posedge clock);
		#1;
		check("aborted", {scl_oe, sda_oe, buffer_full_flag}, 3'h0); // abort
		@(posedge clock) reset_n <= 1'b1;
		$display("test reset done");
	endtask : t_reset
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		t_tx(8'ha5, 1'b0, 1'b0);
		@(posedge clock) {sleep_mode, interrupt_enable} <= 2'b11;
		t_rx(8'hc3, 1'b0);
		t_ack(1'b0);
		t_rx(8'h3c, 1'b1);
		go(4, 8'h00);
		check("read clears full", buffer_full_flag, 1'b0); // read
		go(6, 8'h00);
		t_ack(1'b1);
		t_tx(8'h81, 1'b1, 1'b1);
		t_stop();
		t_reset();
		close_out();
	end
	initial
	begin
		#200000;
		mismatches++;
		close_out();
	end
endmodule : tb_top
bind i2cmbe_engine i2cmbe_chk chk (.clock, .reset_n, .baud_reload, .buf_write, .recv_start,
	.ack_data_bit, .collision_clear, .interrupt_enable, .sleep_mode, .scl_in, .scl_oe,
	.sda_oe, .buffer_full_flag, .write_collision_flag, .receive_overflow_flag,
	.receive_enable_bit, .ack_sequence_enable, .stop_enable_bit, .stop_detected,
	.port_interrupt_flag, .wake_request);
